// ---- bench/dsg_sync_gen_assertions.sv ----
// Checker: bus response and sync output properties of the pulse generator.
// Assumes binding to dsg_sync_gen; sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module dsg_sync_gen_assertions (
  input wire logic                        mclk,
  input wire logic                        nrst,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [dsg_pkg::ADDR_W-1:0]  paddr,
  input wire logic [dsg_pkg::DATA_W-1:0]  pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [dsg_pkg::DATA_W-1:0]  prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic                        hsync,
  input wire logic                        vsync
);
  import dsg_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire logic acc    = psel && penable;
  wire logic mapped = paddr <= 8'h1C && paddr[1:0] == 2'h0;

  property p_ready; pready == acc; endproperty
  a_ready: assert property (p_ready)
    else $error("pready differs from access phase");
  property p_bad; acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_bad: assert property (p_bad)
    else $error("unmapped access not refused");
  property p_ro; acc && pwrite && paddr == OFS_STATUS |-> pslverr; endproperty
  a_ro: assert property (p_ro)
    else $error("status write not refused");
  property p_ok; acc && mapped && !(pwrite && paddr == OFS_STATUS) |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok)
    else $error("legal access refused");
  property p_pos; acc && !pwrite && mapped && paddr <= OFS_F2_END
    |-> (prdata & ~POS_MASK) == 32'h0; endproperty
  a_pos: assert property (p_pos)
    else $error("position reserved bits not zero");
  property p_ctl; acc && !pwrite && paddr == OFS_CTRL
    |-> (prdata & ~CTRL_MASK) == 32'h0; endproperty
  a_ctl: assert property (p_ctl)
    else $error("control reserved bits not zero");
  property p_hold; acc && !pwrite |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed after access");
  property p_off; acc && pwrite && paddr == OFS_CTRL && pstrb[0] && !pwdata[0]
    |-> ##2 (!hsync && !vsync); endproperty
  a_off: assert property (p_off)
    else $error("sync outputs active after disable");
endmodule // dsg_sync_gen_assertions

`default_nettype wire

// ---- bench/dsg_sync_rx.sv ----
// Display receiver model: measures sync pulse widths and line period.
// Assumes active-high sync levels that change on rising mclk edges.
`timescale 1ns/1ps
`default_nettype none

module dsg_sync_rx (
  input wire logic mclk,
  input wire logic hsync,
  input wire logic vsync
);
  int   cyc    = 0;
  int   h_rise = 0;
  int   hw     = 0;
  int   hp     = 0;
  int   v_rise = 0;
  int   vn     = 0;
  int   vw [4] = '{default: 0};
  logic h_q    = 1'b0;
  logic v_q    = 1'b0;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    h_q <= hsync;
    v_q <= vsync;
    if (hsync && !h_q) begin
      hp     <= cyc - h_rise;
      h_rise <= cyc;
    end
    if (!hsync && h_q) begin
      hw <= cyc - h_rise;
    end
    if (vsync && !v_q) begin
      v_rise <= cyc;
    end
    if (!vsync && v_q) begin
      vw[vn % 4] <= cyc - v_rise;
      vn         <= vn + 1;
    end
  end
endmodule // dsg_sync_rx

`default_nettype wire

// ---- bench/tb.sv ----
// Testbench: register access and sync timing of the pulse generator.
// Assumes dsg_sync_gen as the device and dsg_sync_rx on its sync pins.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dsg_pkg::*;
  logic        mclk    = 1'b0;
  logic        nrst    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  pstrb   = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        hsync;
  logic        vsync;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          tests_run = 0;
  int          vn0;
  logic [7:0]  ca [7] = '{OFS_SIZE, OFS_HSYNC_POS, OFS_F1_BEGIN, OFS_F1_END,
                          OFS_F2_BEGIN, OFS_F2_END, OFS_CTRL};
  logic [31:0] cd [7] = '{32'h0003_0009, 32'h0005_0002, 32'h0001_0003,
                          32'h0002_0004, 32'h0000_0005, 32'h0002_0008,
                          32'h0000_1001};

  initial forever #12.5 mclk = ~mclk;

  dsg_sync_gen i_dut (.mclk(mclk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync(hsync), .vsync(vsync));
  dsg_sync_rx i_rx (.mclk(mclk), .hsync(hsync), .vsync(vsync));

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; returns read data and error flag in rd and er
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(rd, POS_RESET);
      chk({31'h0, er}, 32'h0);
    end
    xfer(1'b0, OFS_CTRL, 32'h0);
    chk(rd, CTRL_RESET);
    xfer(1'b0, OFS_SIZE, 32'h0);
    chk(rd, SIZE_RESET);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0FFF_0FFF);
    end
    // Byte lanes 0 and 2 only; lanes 1 and 3 keep their old contents
    pstrb <= 4'h5;
    xfer(1'b1, OFS_HSYNC_POS, 32'h33A5_CC5A);
    pstrb <= 4'hF;
    xfer(1'b0, OFS_HSYNC_POS, 32'h0);
    chk(rd, 32'h0FA5_0F5A);
    xfer(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    xfer(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    chk({31'h0, er}, 32'h1);
    // Ten pixels per line, four lines per field, divisor one
    vn0 = i_rx.vn;
    for (int i = 0; i < 7; i++) begin
      xfer(1'b1, ca[i], cd[i]);
    end
    repeat (200) @(posedge mclk);
    chk(i_rx.hw, 32'd3);
    chk(i_rx.hp, 32'd10);
    chk(i_rx.vw[vn0 % 4], 32'd11);
    chk(i_rx.vw[(vn0 + 1) % 4], 32'd23);
    xfer(1'b0, OFS_SIZE, 32'h0);
    chk(rd, cd[0]);
    chk({31'h0, er}, 32'h0);
    xfer(1'b1, OFS_CTRL, 32'h0000_2001);
    repeat (200) @(posedge mclk);
    chk(i_rx.hw, 32'd6);
    chk(i_rx.hp, 32'd20);
    // A divisor of zero counts as one
    xfer(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (200) @(posedge mclk);
    chk(i_rx.hw, 32'd3);
    chk(i_rx.hp, 32'd10);
    xfer(1'b1, OFS_CTRL, 32'h0000_2000);
    repeat (3) @(posedge mclk);
    xfer(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    chk({30'h0, hsync, vsync}, 32'h0);
    wrap_up();
  end
endmodule // tb

bind dsg_sync_gen dsg_sync_gen_assertions i_chk (.mclk(mclk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .hsync(hsync), .vsync(vsync));

`default_nettype wire

// ---- hw/dsg_pkg.sv ----
// Constants, register map and state types of the display sync pulse generator.
// Assumes a 32-bit APB register port and one clock, mclk.
`default_nettype none

package dsg_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Bus and field geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          POS_W         = 12;
  localparam int          POS_LO_LSB    = 0;
  localparam int          POS_HI_LSB    = 16;
  localparam int          DIV_LSB       = 12;
  localparam int          DIV_W         = 4;
  localparam int          ENABLE_BIT    = 0;
  localparam int          ST_FIELD_BIT  = 28;
  localparam int          ST_HSYNC_BIT  = 29;
  localparam int          ST_VSYNC_BIT  = 30;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0]  OFS_HSYNC_POS = 8'h00;
  localparam logic [7:0]  OFS_F1_BEGIN  = 8'h04;
  localparam logic [7:0]  OFS_F1_END    = 8'h08;
  localparam logic [7:0]  OFS_F2_BEGIN  = 8'h0C;
  localparam logic [7:0]  OFS_F2_END    = 8'h10;
  localparam logic [7:0]  OFS_CTRL      = 8'h14;
  localparam logic [7:0]  OFS_SIZE      = 8'h18;
  localparam logic [7:0]  OFS_STATUS    = 8'h1C;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values and writable-bit masks
  localparam logic [31:0] POS_RESET     = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_1000;
  localparam logic [31:0] SIZE_RESET    = 32'h0106_0359;
  localparam logic [31:0] POS_MASK      = 32'h0FFF_0FFF;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_F001;
  localparam logic [31:0] SIZE_MASK     = 32'h0FFF_0FFF;

  typedef enum logic {
    FIELD_ONE = 1'b0,
    FIELD_TWO = 1'b1
  } dsg_field_t;

  typedef struct packed {
    logic [31:0] hsync_pos;
    logic [31:0] f1_begin;
    logic [31:0] f1_end;
    logic [31:0] f2_begin;
    logic [31:0] f2_end;
    logic [31:0] ctrl;
    logic [31:0] size;
    logic [31:0] rdata;
    logic [3:0]  clk_cnt;
    logic [11:0] pixel;
    logic [11:0] line;
    dsg_field_t  field;
  } dsg_regs_t;

  typedef struct packed {
    logic level;
  } dsg_level_t;

endpackage : dsg_pkg

`default_nettype wire

// ---- hw/dsg_sync_gen.sv ----
// Display sync pulse generator: APB registers, frame counters, sync outputs.
// Assumes an APB master on mclk, and a display encoder sampling hsync/vsync.
//
// What this block does
// - hsync goes active when the pixel counter equals line_sync_begin_pixel.
// - hsync goes inactive when the pixel counter equals line_sync_end_pixel.
// - Both hsync position fields are 12-bit read/write, resetting to zero.
// - Field 1: vsync asserts at matching begin line and begin pixel.
// - Field 1: vsync deasserts at matching end line and end pixel.
// - Field 2: vsync asserts at its own begin line and pixel.
// - Field 2: vsync deasserts at its own end line and pixel.
// - Reserved bits read zero; writes to them are dropped.
// - Vsync line and pixel fields are 12-bit, range zero to FFF, reset zero.
// - Pixel counter advances once every pixel_increment_divisor clocks.
`timescale 1ns/1ps
`default_nettype none

module dsg_sync_gen (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [dsg_pkg::ADDR_W-1:0] paddr,
  input  wire logic [dsg_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [dsg_pkg::DATA_W-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic                        hsync,
  output logic                        vsync
);
  import dsg_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Merge a write under byte strobes, then clear reserved bits
  function automatic logic [31:0] merge_write(
    input logic [31:0] old_val,
    input logic [31:0] wr_val,
    input logic [3:0]  strb,
    input logic [31:0] keep
  );
    logic [31:0] lanes;
    lanes = '0;
    for (int b = 0; b < 4; b++) begin
      lanes[b*8 +: 8] = {8{strb[b]}};
    end
    return ((old_val & ~lanes) | (wr_val & lanes)) & keep;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    if (addr == OFS_HSYNC_POS) begin
      hit = 1'b1;
    end else if (addr == OFS_F1_BEGIN) begin
      hit = 1'b1;
    end else if (addr == OFS_F1_END) begin
      hit = 1'b1;
    end else if (addr == OFS_F2_BEGIN) begin
      hit = 1'b1;
    end else if (addr == OFS_F2_END) begin
      hit = 1'b1;
    end else if (addr == OFS_CTRL) begin
      hit = 1'b1;
    end else if (addr == OFS_SIZE) begin
      hit = 1'b1;
    end else if (addr == OFS_STATUS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // Low 12-bit field of a position word
  function automatic logic [POS_W-1:0] lo_pos(input logic [31:0] w);
    return w[POS_LO_LSB +: POS_W];
  endfunction

  // High 12-bit field of a position word
  function automatic logic [POS_W-1:0] hi_pos(input logic [31:0] w);
    return w[POS_HI_LSB +: POS_W];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  dsg_regs_t        s;
  dsg_regs_t        next_s;

  logic             setup_phase;
  logic             access_phase;
  logic             wr_commit;
  logic             bad_access;
  logic             enabled;
  logic [DIV_W-1:0] divisor;
  logic [DIV_W-1:0] last_tick;
  logic             pixel_tick;
  logic             line_wrap;
  logic             field_wrap;
  logic [POS_W-1:0] pixel_last;
  logic [POS_W-1:0] line_last;
  logic [31:0]      vs_begin_word;
  logic [31:0]      vs_end_word;
  logic             h_begin_hit;
  logic             h_end_hit;
  logic             v_begin_hit;
  logic             v_end_hit;
  logic [31:0]      status_word;
  logic [31:0]      read_word;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  // Status is read-only; writes to it or to holes are refused
  assign bad_access   = ~is_mapped(paddr) | (pwrite & (paddr == OFS_STATUS));
  assign wr_commit    = access_phase & pwrite & ~bad_access;

  // Zero wait states: every access completes in its first access cycle
  assign pready  = access_phase;
  assign pslverr = access_phase & bad_access;
  assign prdata  = s.rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Counter control

  assign enabled    = s.ctrl[ENABLE_BIT];
  assign divisor    = s.ctrl[DIV_LSB +: DIV_W];
  // A divisor of zero behaves as one
  assign last_tick  = (divisor == 4'h0) ? 4'h0 : divisor - 4'h1;
  assign pixel_tick = enabled & (s.clk_cnt >= last_tick);
  assign pixel_last = lo_pos(s.size);
  assign line_last  = hi_pos(s.size);
  assign line_wrap  = pixel_tick & (s.pixel >= pixel_last);
  assign field_wrap = line_wrap & (s.line >= line_last);

  //////////////////////////////////////////////////////////////////////////////
  // Sync compares

  assign h_begin_hit = enabled & (s.pixel == lo_pos(s.hsync_pos));
  assign h_end_hit   = enabled & (s.pixel == hi_pos(s.hsync_pos));

  always_comb begin
    vs_begin_word = s.f1_begin;
    vs_end_word   = s.f1_end;
    case (s.field)
      FIELD_ONE: begin
        vs_begin_word = s.f1_begin;
        vs_end_word   = s.f1_end;
      end
      FIELD_TWO: begin
        vs_begin_word = s.f2_begin;
        vs_end_word   = s.f2_end;
      end
      default: begin
        vs_begin_word = s.f1_begin;
        vs_end_word   = s.f1_end;
      end
    endcase
  end

  // Line must match in the high field and pixel in the low field
  assign v_begin_hit = enabled
                     & (s.line  == hi_pos(vs_begin_word))
                     & (s.pixel == lo_pos(vs_begin_word));
  assign v_end_hit   = enabled
                     & (s.line  == hi_pos(vs_end_word))
                     & (s.pixel == lo_pos(vs_end_word));

  //////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    status_word = '0;
    status_word[POS_LO_LSB +: POS_W] = s.pixel;
    status_word[POS_HI_LSB +: POS_W] = s.line;
    status_word[ST_FIELD_BIT]        = (s.field == FIELD_TWO);
    status_word[ST_HSYNC_BIT]        = hsync;
    status_word[ST_VSYNC_BIT]        = vsync;
  end

  always_comb begin
    read_word = '0;
    if (paddr == OFS_HSYNC_POS) begin
      read_word = s.hsync_pos;
    end else if (paddr == OFS_F1_BEGIN) begin
      read_word = s.f1_begin;
    end else if (paddr == OFS_F1_END) begin
      read_word = s.f1_end;
    end else if (paddr == OFS_F2_BEGIN) begin
      read_word = s.f2_begin;
    end else if (paddr == OFS_F2_END) begin
      read_word = s.f2_end;
    end else if (paddr == OFS_CTRL) begin
      read_word = s.ctrl;
    end else if (paddr == OFS_SIZE) begin
      read_word = s.size;
    end else if (paddr == OFS_STATUS) begin
      read_word = status_word;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s = s;

    // Read data is captured in the setup cycle, valid for the access cycle
    if (setup_phase) begin
      next_s.rdata = pwrite ? 32'h0000_0000 : read_word;
    end

    // Register writes; stored words never hold reserved bits
    if (wr_commit) begin
      if (paddr == OFS_HSYNC_POS) begin
        next_s.hsync_pos = merge_write(s.hsync_pos, pwdata, pstrb, POS_MASK);
      end else if (paddr == OFS_F1_BEGIN) begin
        next_s.f1_begin = merge_write(s.f1_begin, pwdata, pstrb, POS_MASK);
      end else if (paddr == OFS_F1_END) begin
        next_s.f1_end = merge_write(s.f1_end, pwdata, pstrb, POS_MASK);
      end else if (paddr == OFS_F2_BEGIN) begin
        next_s.f2_begin = merge_write(s.f2_begin, pwdata, pstrb, POS_MASK);
      end else if (paddr == OFS_F2_END) begin
        next_s.f2_end = merge_write(s.f2_end, pwdata, pstrb, POS_MASK);
      end else if (paddr == OFS_CTRL) begin
        next_s.ctrl = merge_write(s.ctrl, pwdata, pstrb, CTRL_MASK);
      end else if (paddr == OFS_SIZE) begin
        next_s.size = merge_write(s.size, pwdata, pstrb, SIZE_MASK);
      end
    end

    // Frame counters; stopped and cleared while disabled
    if (!enabled) begin
      next_s.clk_cnt = 4'h0;
      next_s.pixel   = 12'h000;
      next_s.line    = 12'h000;
      next_s.field   = FIELD_ONE;
    end else if (pixel_tick) begin
      next_s.clk_cnt = 4'h0;
      if (line_wrap) begin
        next_s.pixel = 12'h000;
        if (field_wrap) begin
          next_s.line  = 12'h000;
          next_s.field = (s.field == FIELD_ONE) ? FIELD_TWO : FIELD_ONE;
        end else begin
          next_s.line = s.line + 12'h001;
        end
      end else begin
        next_s.pixel = s.pixel + 12'h001;
      end
    end else begin
      next_s.clk_cnt = s.clk_cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s           <= '0;
      s.hsync_pos <= POS_RESET;
      s.f1_begin  <= POS_RESET;
      s.f1_end    <= POS_RESET;
      s.f2_begin  <= POS_RESET;
      s.f2_end    <= POS_RESET;
      s.ctrl      <= CTRL_RESET;
      s.size      <= SIZE_RESET;
      s.field     <= FIELD_ONE;
    end else begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sync outputs

  dsg_sync_level u_hsync (
    .mclk      (mclk),
    .nrst      (nrst),
    .enable    (enabled),
    .begin_hit (h_begin_hit),
    .end_hit   (h_end_hit),
    .level     (hsync)
  );

  dsg_sync_level u_vsync (
    .mclk      (mclk),
    .nrst      (nrst),
    .enable    (enabled),
    .begin_hit (v_begin_hit),
    .end_hit   (v_end_hit),
    .level     (vsync)
  );

endmodule // dsg_sync_gen

`default_nettype wire

// ---- hw/dsg_sync_level.sv ----
// One sync output: a level set by a begin match and cleared by an end match.
// Assumes begin and end hits are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none

module dsg_sync_level (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic begin_hit,
  input  wire logic end_hit,
  output logic      level
);
  import dsg_pkg::*;

  dsg_level_t s;
  dsg_level_t next_s;

  always_comb begin
    next_s = s;
    if (!enable) begin
      next_s.level = 1'b0;
    end else if (begin_hit) begin
      next_s.level = 1'b1;
    end else if (end_hit) begin
      next_s.level = 1'b0;
    end
    // Otherwise the level is held between matches
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level = s.level;

endmodule // dsg_sync_level

`default_nettype wire
